// file: drain_pkg.sv
// constants for the emergency discharge timer: register map, fields, timing
package drain_pkg;
    // register byte addresses on the apb bus
    localparam logic [11:0] CONFIG_ADDR = 12'h000;
    localparam logic [11:0] CONTROL_ADDR = 12'h004;
    localparam logic [11:0] STATUS_ADDR = 12'h008;
    // discharge_config field positions
    localparam int WIN_LSB = 13;
    localparam int RSVD_BIT = 12;
    localparam int CNT_LSB = 8;
    localparam int TMO_LSB = 0;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    // control and status bit positions
    localparam int ENABLE_BIT = 0;
    localparam int ACTIVE_BIT = 0;
    localparam int SWITCH_BIT = 1;
    localparam int EXPIRED_BIT = 2;
    // timing: every slow rate is derived from one base tick
    localparam int CLK_HZ = 10_000_000;
    localparam int BASE_TICK_US = 62_500;
    localparam int BASE_TICK_CYCLES = (CLK_HZ / 1_000_000) * BASE_TICK_US;
    localparam int TICKS_PER_S = 1_000_000 / BASE_TICK_US;
    localparam int WINDOW_STEP_DS = 75;
    localparam int WINDOW_STEP_TICKS = WINDOW_STEP_DS * TICKS_PER_S / 10;
    localparam int CYCLE_S = 60;
    localparam int CYCLE_TICKS = CYCLE_S * TICKS_PER_S;
    localparam int ACTIVITY_HZ = 2;
    localparam int ACTIVITY_TICKS = TICKS_PER_S / ACTIVITY_HZ;
    localparam int TIMEOUT_STEP_H = 2;
    localparam int TIMEOUT_STEP_TICKS = TIMEOUT_STEP_H * 3600 * TICKS_PER_S;
    localparam logic [2:0] WIN_MAX = 3'h7;
endpackage : drain_pkg

// file: emergency_discharge_timer.sv
// emergency discharge timer: duty cycle, activity counter, timeout, apb slave
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module emergency_discharge_timer #(
    parameter int BASE_TICK_CYCLES = drain_pkg::BASE_TICK_CYCLES,
    parameter int TIMEOUT_STEP_TICKS = drain_pkg::TIMEOUT_STEP_TICKS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic switch_on_o,
    output logic drain_active_o
);
    typedef struct packed {
        logic [2:0] win;
        logic [7:0] tmo;
        logic [3:0] cnt;
        logic en;
        logic [9:0] phase;
        logic [2:0] sub;
        logic [16:0] step;
        logic [8:0] steps;
        logic expired;
        logic active;
        logic sw_on;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dis_state_t;

    dis_state_t r;
    dis_state_t s;
    logic tick;

    // on length in base ticks; code 7 leaves a single 62.5 ms off tick
    function automatic logic [9:0] on_ticks(input logic [2:0] win);
        logic [9:0] t;
        t = 10'(({7'h00, win} + 10'h001) * 10'(drain_pkg::WINDOW_STEP_TICKS));
        if (win == drain_pkg::WIN_MAX)
        begin
            t = 10'(drain_pkg::CYCLE_TICKS - 1);
        end
        return t;
    endfunction : on_ticks

    function automatic logic [31:0] config_word(input dis_state_t v);
        logic [31:0] w;
        w = 32'h00000000;
        w[drain_pkg::WIN_LSB +: 3] = v.win;
        w[drain_pkg::RSVD_BIT] = 1'b0;
        w[drain_pkg::CNT_LSB +: 4] = v.cnt;
        w[drain_pkg::TMO_LSB +: 8] = v.tmo;
        return w;
    endfunction : config_word

    tick_divider #(
        .CYCLES(BASE_TICK_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(r.active),
        .tick_o(tick)
    );

    always_comb
    begin
        s = r;
        // one wait state: pready rises in the second access cycle
        s.pready = psel_i && penable_i && !r.pready;
        s.pslverr = 1'b0;
        if (s.pready)
        begin
            s.prdata = 32'h00000000;
            unique case (paddr_i)
                drain_pkg::CONFIG_ADDR: s.prdata = config_word(r);
                drain_pkg::CONTROL_ADDR: s.prdata[drain_pkg::ENABLE_BIT] = r.en;
                drain_pkg::STATUS_ADDR:
                begin
                    s.prdata[drain_pkg::ACTIVE_BIT] = r.active;
                    s.prdata[drain_pkg::SWITCH_BIT] = r.sw_on;
                    s.prdata[drain_pkg::EXPIRED_BIT] = r.expired;
                end
                default: s.pslverr = 1'b1;
            endcase
        end
        // writes land only at the completing edge; the counter field is read-only
        if (psel_i && penable_i && r.pready && pwrite_i)
        begin
            if (paddr_i == drain_pkg::CONFIG_ADDR)
            begin
                s.win = pwdata_i[drain_pkg::WIN_LSB +: 3];
                s.tmo = pwdata_i[drain_pkg::TMO_LSB +: 8];
            end
            else if (paddr_i == drain_pkg::CONTROL_ADDR)
            begin
                s.en = pwdata_i[drain_pkg::ENABLE_BIT];
            end
        end
        if (r.active && tick)
        begin
            // 60 s cycle, repeated for every cycle of the mode
            if (r.phase == 10'(drain_pkg::CYCLE_TICKS - 1))
            begin
                s.phase = 10'h000;
            end
            else
            begin
                s.phase = r.phase + 10'h001;
            end
            s.sub = r.sub + 3'h1;
            if (r.sub == 3'(drain_pkg::ACTIVITY_TICKS - 1))
            begin
                s.cnt = r.cnt + 4'h1;
            end
            if (r.step == 17'(TIMEOUT_STEP_TICKS - 1))
            begin
                s.step = 17'h00000;
                s.steps = r.steps + 9'h001;
                if (s.steps >= {1'b0, r.tmo} + 9'h001)
                begin
                    s.expired = 1'b1;
                end
            end
            else
            begin
                s.step = r.step + 17'h00001;
            end
        end
        if (!r.active)
        begin
            s.phase = 10'h000;
            s.sub = 3'h0;
        end
        if (!s.en)
        begin
            s.step = 17'h00000;
            s.steps = 9'h000;
            s.expired = 1'b0;
        end
        // a zero timeout drops the mode at the same edge that writes it
        s.active = s.en && (s.tmo != 8'h00) && !s.expired;
        s.sw_on = s.active && (s.phase < on_ticks(s.win));
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r <= '0;
            r.win <= drain_pkg::CONFIG_RESET[drain_pkg::WIN_LSB +: 3];
            r.cnt <= drain_pkg::CONFIG_RESET[drain_pkg::CNT_LSB +: 4];
            r.tmo <= drain_pkg::CONFIG_RESET[drain_pkg::TMO_LSB +: 8];
        end
        else
        begin
            r <= s;
        end
    end

    assign prdata_o = r.prdata;
    assign pready_o = r.pready;
    assign pslverr_o = r.pslverr;
    assign switch_on_o = r.sw_on;
    assign drain_active_o = r.active;

    property p_needs_enable;
        @(posedge clk_i) disable iff (rst_i)
        !r.en |-> !r.active && !switch_on_o;
    endproperty
    a_needs_enable: assert property (p_needs_enable)
        else $error("mode active without enable");

    property p_window_length;
        @(posedge clk_i) disable iff (rst_i)
        r.active && r.win != 3'h7 |->
            switch_on_o == (r.phase < 10'(({7'h00, r.win} + 10'h001) * 10'h078));
    endproperty
    a_window_length: assert property (p_window_length)
        else $error("switch state does not match on-window");

    property p_code7_off;
        @(posedge clk_i) disable iff (rst_i)
        r.active && r.win == 3'h7 |-> switch_on_o == (r.phase != 10'h3BF);
    endproperty
    a_code7_off: assert property (p_code7_off)
        else $error("code 7 off window wrong");

    property p_phase_wrap;
        @(posedge clk_i) disable iff (rst_i)
        r.active && tick && r.phase == 10'h3BF && r.en |=> r.phase == 10'h000;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap)
        else $error("discharge cycle did not wrap at 60 s");

    property p_rsvd_zero;
        @(posedge clk_i) disable iff (rst_i)
        pready_o && !pslverr_o |-> prdata_o[12] == 1'b0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bit read as one");

    property p_cnt_wrap;
        @(posedge clk_i) disable iff (rst_i)
        r.active && tick && r.sub == 3'h7 && r.cnt == 4'hF |=> r.cnt == 4'h0;
    endproperty
    a_cnt_wrap: assert property (p_cnt_wrap)
        else $error("activity counter did not wrap");

    property p_cnt_idle;
        @(posedge clk_i) disable iff (rst_i)
        !r.active |=> $stable(r.cnt);
    endproperty
    a_cnt_idle: assert property (p_cnt_idle)
        else $error("activity counter moved while idle");

    property p_zero_timeout;
        @(posedge clk_i) disable iff (rst_i)
        r.tmo == 8'h00 |-> !drain_active_o && !switch_on_o;
    endproperty
    a_zero_timeout: assert property (p_zero_timeout)
        else $error("mode active with zero timeout");

    property p_timer_clear;
        @(posedge clk_i) disable iff (rst_i)
        !r.en |-> r.step == 17'h00000 && r.steps == 9'h000 && !r.expired;
    endproperty
    a_timer_clear: assert property (p_timer_clear)
        else $error("timeout timer not cleared");

    property p_expire_ends;
        @(posedge clk_i) disable iff (rst_i)
        $rose(r.expired) |-> !drain_active_o ##1 !drain_active_o;
    endproperty
    a_expire_ends: assert property (p_expire_ends)
        else $error("mode continued after timeout");

    property p_expire_count;
        @(posedge clk_i) disable iff (rst_i)
        $rose(r.expired) |-> r.steps == {1'b0, r.tmo} + 9'h001;
    endproperty
    a_expire_count: assert property (p_expire_count)
        else $error("timeout ended at wrong step count");

    property p_reset_clear;
        @(posedge clk_i)
        rst_i |=> r.win == 3'h0 && r.cnt == 4'h0 && r.tmo == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("config fields not cleared by reset");

    property p_switch_needs_mode;
        @(posedge clk_i) disable iff (rst_i)
        switch_on_o |-> drain_active_o;
    endproperty
    a_switch_needs_mode: assert property (p_switch_needs_mode)
        else $error("switches on outside discharge mode");

    property p_cnt_step;
        @(posedge clk_i) disable iff (rst_i)
        r.active && tick && r.sub == 3'h7 |=> r.cnt == $past(r.cnt) + 4'h1;
    endproperty
    a_cnt_step: assert property (p_cnt_step)
        else $error("activity counter missed its 2 Hz step");

    property p_zero_write;
        @(posedge clk_i) disable iff (rst_i)
        psel_i && penable_i && pready_o && pwrite_i && paddr_i == drain_pkg::CONFIG_ADDR
            && pwdata_i[drain_pkg::TMO_LSB +: 8] == 8'h00 |=> !drain_active_o;
    endproperty
    a_zero_write: assert property (p_zero_write)
        else $error("zero timeout write did not end the mode");

    property p_fields_hold;
        @(posedge clk_i) disable iff (rst_i)
        !(psel_i && penable_i && pready_o && pwrite_i) |=> $stable(r.win) && $stable(r.tmo);
    endproperty
    a_fields_hold: assert property (p_fields_hold)
        else $error("configuration changed without a write");

    property p_timer_frozen;
        @(posedge clk_i) disable iff (rst_i)
        r.en && !r.active |=> !r.en || ($stable(r.step) && $stable(r.steps));
    endproperty
    a_timer_frozen: assert property (p_timer_frozen)
        else $error("timeout timer moved while the mode was stopped");
endmodule : emergency_discharge_timer

// file: emergency_discharge_timer_bench.sv
// self-checking bench for the emergency discharge timer over apb
`timescale 1ns/100ps
module emergency_discharge_timer_bench;
    // short base tick and timeout step keep the 60 s cycle and 2 h steps simulable
    localparam int TICK = 4;
    localparam int STEP = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic switch_on_o;
    logic drain_active_o;
    logic [31:0] rd;
    logic err;
    logic [3:0] a;
    logic [2:0] c;
    int fails = 0;
    int check_count = 0;
    int on_n, off_n, on2, off2, exp_on;

    emergency_discharge_timer #(.BASE_TICK_CYCLES(TICK), .TIMEOUT_STEP_TICKS(STEP)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .switch_on_o(switch_on_o),
        .drain_active_o(drain_active_o)
    );

    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    task results();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    // the switch edge may land one clock either side of the base tick
    task near(input int got, input int exp, input string msg);
        check_count++;
        if (got < exp - 1 || got > exp + 1)
        begin
            fails++;
            $display("unexpected at %0t: %s got %0d want %0d", $time, msg, got, exp);
        end
    endtask : near

    // one apb transfer; request held until pready is sampled high
    task bus(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= data;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // a slave that never answers is caught by the watchdog
        do
        begin
            @(posedge clk_i);
        end
        while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : bus

    // clocks spent high, then low, on the switch output
    task measure(output int hi, output int lo);
        int n;
        n = 0;
        while (switch_on_o !== 1'b1 && n < 9000)
        begin
            @(posedge clk_i);
            n++;
        end
        hi = 0;
        while (switch_on_o === 1'b1 && hi < 9000)
        begin
            hi++;
            @(posedge clk_i);
        end
        lo = 0;
        while (switch_on_o !== 1'b1 && lo < 9000)
        begin
            lo++;
            @(posedge clk_i);
        end
    endtask : measure

    task span(output int n);
        n = 0;
        while (drain_active_o !== 1'b1 && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        n = 0;
        while (drain_active_o === 1'b1 && n < 9000)
        begin
            n++;
            @(posedge clk_i);
        end
    endtask : span

    initial
    begin
        repeat (80000) @(posedge clk_i);
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, drain_pkg::CONFIG_ADDR, 32'h00000000);
        chk(rd, 32'h00000000, "config reset");
        bus(1'b0, 12'h00C, 32'h00000000);
        chk({31'h00000000, err}, 32'h00000001, "unmapped error");
        bus(1'b1, drain_pkg::CONFIG_ADDR, 32'h0000FFFF);
        bus(1'b0, drain_pkg::CONFIG_ADDR, 32'h00000000);
        chk(rd, 32'h0000E0FF, "config fields");
        $display("test registers done");
        bus(1'b1, drain_pkg::CONTROL_ADDR, 32'h00000001);
        bus(1'b0, drain_pkg::CONFIG_ADDR, 32'h00000000);
        a = rd[11:8];
        // both reads sample the counter at the same offset from their start
        repeat (8 * TICK * 3 - 3) @(posedge clk_i);
        bus(1'b0, drain_pkg::CONFIG_ADDR, 32'h00000000);
        chk({28'h0000000, rd[11:8]}, {28'h0000000, a + 4'h3}, "counter rate");
        a = rd[11:8];
        repeat (8 * TICK * 16 - 3) @(posedge clk_i);
        bus(1'b0, drain_pkg::CONFIG_ADDR, 32'h00000000);
        chk({28'h0000000, rd[11:8]}, {28'h0000000, a}, "counter wrap");
        bus(1'b1, drain_pkg::CONTROL_ADDR, 32'h00000000);
        bus(1'b0, drain_pkg::CONFIG_ADDR, 32'h00000000);
        a = rd[11:8];
        repeat (200) @(posedge clk_i);
        bus(1'b0, drain_pkg::CONFIG_ADDR, 32'h00000000);
        chk({28'h0000000, rd[11:8]}, {28'h0000000, a}, "counter stops");
        $display("test activity counter done");
        for (int i = 0; i < 8; i++)
        begin
            c = i[2:0];
            exp_on = (i == 7) ? 959 * TICK : (i + 1) * 120 * TICK;
            bus(1'b1, drain_pkg::CONFIG_ADDR, {16'h0000, c, 13'h00FF});
            bus(1'b1, drain_pkg::CONTROL_ADDR, 32'h00000001);
            measure(on_n, off_n);
            measure(on2, off2);
            near(on_n, exp_on, "on time");
            near(off_n, 960 * TICK - exp_on, "off time");
            near(on2, exp_on, "second on time");
            bus(1'b1, drain_pkg::CONTROL_ADDR, 32'h00000000);
        end
        $display("test duty cycle done");
        bus(1'b1, drain_pkg::CONFIG_ADDR, 32'h00000001);
        bus(1'b1, drain_pkg::CONTROL_ADDR, 32'h00000001);
        span(on_n);
        near(on_n, 2 * STEP * TICK, "timeout length");
        bus(1'b0, drain_pkg::STATUS_ADDR, 32'h00000000);
        chk(rd & 32'h00000005, 32'h00000004, "expired status");
        bus(1'b1, drain_pkg::CONTROL_ADDR, 32'h00000000);
        bus(1'b1, drain_pkg::CONTROL_ADDR, 32'h00000001);
        span(on_n);
        near(on_n, 2 * STEP * TICK, "timer restarts");
        bus(1'b1, drain_pkg::CONTROL_ADDR, 32'h00000000);
        bus(1'b1, drain_pkg::CONFIG_ADDR, 32'h000000FF);
        bus(1'b1, drain_pkg::CONTROL_ADDR, 32'h00000001);
        repeat (2) @(posedge clk_i);
        chk({31'h00000000, drain_active_o}, 32'h00000001, "mode running");
        bus(1'b0, drain_pkg::STATUS_ADDR, 32'h00000000);
        chk(rd & 32'h00000007, 32'h00000003, "status running");
        bus(1'b0, drain_pkg::CONTROL_ADDR, 32'h00000000);
        chk(rd, 32'h00000001, "enable readback");
        bus(1'b1, drain_pkg::CONFIG_ADDR, 32'h00000000);
        repeat (2) @(posedge clk_i);
        chk({31'h00000000, drain_active_o}, 32'h00000000, "zero ends mode");
        repeat (20) @(posedge clk_i);
        chk({31'h00000000, drain_active_o}, 32'h00000000, "zero stays off");
        bus(1'b1, drain_pkg::CONTROL_ADDR, 32'h00000000);
        bus(1'b1, drain_pkg::CONFIG_ADDR, 32'h000000FF);
        repeat (20) @(posedge clk_i);
        chk({31'h00000000, drain_active_o}, 32'h00000000, "no enable");
        $display("test timeout done");
        bus(1'b1, drain_pkg::CONTROL_ADDR, 32'h00000001);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, drain_pkg::CONFIG_ADDR, 32'h00000000);
        chk(rd, 32'h00000000, "config after reset");
        bus(1'b0, drain_pkg::CONTROL_ADDR, 32'h00000000);
        chk(rd, 32'h00000000, "enable after reset");
        chk({31'h00000000, drain_active_o}, 32'h00000000, "mode off after reset");
        $display("test reset done");
        results();
    end
endmodule : emergency_discharge_timer_bench

// file: tick_divider.sv
// base tick divider: one-cycle enable pulse every CYCLES clocks while run is high
`timescale 1ns/100ps
module tick_divider #(
    parameter int CYCLES = drain_pkg::BASE_TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    output logic tick_o
);
    typedef struct packed {
        logic [19:0] count;
        logic tick;
    } div_state_t;

    div_state_t r;
    div_state_t s;

    always_comb
    begin
        s = r;
        s.tick = 1'b0;
        // restart from zero so the first on-window of a mode is full length
        if (!run_i)
        begin
            s.count = 20'h00000;
        end
        else if (r.count == 20'(CYCLES - 1))
        begin
            s.count = 20'h00000;
            s.tick = 1'b1;
        end
        else
        begin
            s.count = r.count + 20'h00001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= s;
        end
    end

    assign tick_o = r.tick;
endmodule : tick_divider
